//--- shared_bus_device.sv
// device end: demultiplexes the shared bus into address, lanes and data
`default_nettype none
module shared_bus_device (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // bus width strap, high for 16-bit mode
  input  wire logic                  mode16,
  // shared bus
  shared_bus_if.device               bus,
  // user side: held access address and lanes
  output var  shared_bus_pkg::addr_t access_addr,
  output var  shared_bus_pkg::lanes_t access_lanes,
  // user side: data write
  output var  logic                  wr_pulse,
  output var  shared_bus_pkg::word_t wr_word,
  // user side: data read
  output var  logic                  rd_pulse,
  input  wire shared_bus_pkg::word_t rd_word
);
  import shared_bus_pkg::*;

  // ============================================================
  // pin synchronisers
  // every pin is asynchronous to our clock; the strobes and the lines
  // pass the same depth so a sampled word lines up with its strobe edge
  logic  cmd_meta;
  logic  cmd_sync;
  logic  wr_meta;
  logic  wr_sync;
  logic  wr_prev;
  logic  rd_meta;
  logic  rd_sync;
  logic  rd_prev;
  word_t sd_meta;
  word_t sd_sync;
  // the width strap is a pin as well; it is only expected to change
  // while the bus is idle, so two flops are enough
  logic  mode_meta;
  logic  mode_sync;

  // strobes, select and width strap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_meta  <= 1'b0;
      cmd_sync  <= 1'b0;
      wr_meta   <= 1'b1;
      wr_sync   <= 1'b1;
      wr_prev   <= 1'b1;
      rd_meta   <= 1'b1;
      rd_sync   <= 1'b1;
      rd_prev   <= 1'b1;
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end else begin
      cmd_meta  <= bus.cmd;
      cmd_sync  <= cmd_meta;
      wr_meta   <= bus.wr_n;
      wr_sync   <= wr_meta;
      wr_prev   <= wr_sync;
      rd_meta   <= bus.rd_n;
      rd_sync   <= rd_meta;
      rd_prev   <= rd_sync;
      mode_meta <= mode16;
      mode_sync <= mode_meta;
    end
  end

  // shared lines, same depth as the strobes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sd_meta <= WORD_ZERO;
      sd_sync <= WORD_ZERO;
    end else begin
      sd_meta <= bus.sd;
      sd_sync <= sd_meta;
    end
  end

  // ============================================================
  // strobe decode
  // writes are taken when the strobe rises, so the host's setup time
  // across the whole low phase is used
  logic wr_end;
  logic rd_start;
  logic addr_write;
  logic data_write;
  logic data_read;
  logic read_active;

  assign wr_end      = wr_sync & ~wr_prev;
  assign rd_start    = ~rd_sync & rd_prev;
  assign addr_write  = wr_end & cmd_sync;
  assign data_write  = wr_end & ~cmd_sync;
  assign data_read   = rd_start & ~cmd_sync;
  assign read_active = ~rd_sync & ~cmd_sync;

  // ============================================================
  // address phase decode
  // in byte mode the first write is expected next unless a second is due
  typedef enum logic {
    PAIR_FIRST  = 1'b0,
    PAIR_SECOND = 1'b1
  } pair_e;

  // which byte write of a byte-mode address pair comes next
  pair_e  pair;
  logic   second_due;
  addr_t  wide_addr;
  lanes_t wide_lanes;
  addr_t  first_addr;
  lanes_t first_lanes;
  addr_t  second_addr;
  addr_t  next_addr;
  lanes_t next_lanes;
  logic   next_second_due;

  // pins 11, 1 and 0 are not looked at in the wide address phase
  assign wide_addr  = {sd_sync[A16_MSB:A16_LSB], 2'b00};
  assign wide_lanes = sd_sync[LANE_MSB:LANE_LSB];

  // first byte write: pins 7..0 give address bits 7..0
  assign first_addr  = {access_addr[A16_MSB:HIGH_LSB],
                        sd_sync[LOW_MSB:0]};
  // one byte per access in byte mode, picked by the two low bits
  assign first_lanes = lanes_t'(LANE_FIRST << sd_sync[1:0]);

  // second byte write: pins 2..0 give bits 10..8, pins 7..3 ignored
  assign second_addr = {sd_sync[A8_HI_MSB:0],
                        access_addr[LOW_MSB:0]};

  assign second_due = (pair == PAIR_SECOND);
  assign next_addr  = !mode_sync  ? (second_due ? second_addr : first_addr)
                                  : wide_addr;
  assign next_lanes = !mode_sync  ? (second_due ? access_lanes : first_lanes)
                                  : wide_lanes;
  // any data access restarts the byte-mode pair, so a host that lost
  // track of the pair recovers on its next data access
  assign next_second_due = mode_sync  ? 1'b0 :
                           addr_write ? ~second_due :
                           (data_write | data_read) ? 1'b0 : second_due;

  // ============================================================
  // held address and lanes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      access_addr  <= ADDR_ZERO;
      access_lanes <= LANES_ZERO;
      pair         <= PAIR_FIRST;
    end else begin
      pair <= next_second_due ? PAIR_SECOND : PAIR_FIRST;
      if (addr_write) begin
        access_addr  <= next_addr;
        access_lanes <= next_lanes;
      end
    end
  end

  // ============================================================
  // data path
  // the upper byte is masked in byte mode rather than trusted, since a
  // floating or miswired upper half would otherwise corrupt the word
  word_t write_value;
  word_t read_value;

  assign write_value = mode_sync ? sd_sync
                                 : {BYTE_ZERO, sd_sync[LOW_MSB:0]};
  assign read_value  = mode_sync ? rd_word
                              : {BYTE_ZERO, rd_word[LOW_MSB:0]};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_pulse       <= 1'b0;
      wr_word        <= WORD_ZERO;
      rd_pulse       <= 1'b0;
      bus.dev_sd_out <= WORD_ZERO;
      bus.dev_sd_oe  <= 1'b0;
    end else begin
      wr_pulse      <= data_write;
      rd_pulse      <= data_read;
      // limitation: the drive lets go three clocks after the read strobe
      // rises, so the host must leave that gap before driving again
      bus.dev_sd_oe <= read_active;
      if (data_write) begin
        wr_word <= write_value;
      end
      // drive follows the user word for the whole low phase of the strobe
      if (read_active) begin
        bus.dev_sd_out <= read_value;
      end
    end
  end
endmodule : shared_bus_device
`default_nettype wire

//--- shared_bus_pkg.sv
// shared constants and types for the shared address/data host bus
`default_nettype none
package shared_bus_pkg;
  // ============================================================
  // widths and types
  typedef logic [15:0] word_t;
  typedef logic [10:0] addr_t;
  typedef logic [3:0]  lanes_t;
  typedef logic [7:0]  byte_t;

  // ============================================================
  // field positions on the shared pins
  localparam int LANE_MSB     = 15;
  localparam int LANE_LSB     = 12;
  localparam int DONTCARE_PIN = 11;
  localparam int A16_MSB      = 10;
  localparam int A16_LSB      = 2;
  localparam int LOW_MSB      = 7;
  localparam int HIGH_LSB     = 8;
  localparam int A8_HI_MSB    = 2;
  localparam int A8_HI_WIDTH  = 3;

  // ============================================================
  // values after reset and fixed fills
  localparam word_t  WORD_ZERO  = 16'h0000;
  localparam addr_t  ADDR_ZERO  = 11'h000;
  localparam lanes_t LANES_ZERO = 4'h0;
  localparam lanes_t LANE_FIRST = 4'h1;
  localparam byte_t  BYTE_ZERO  = 8'h00;

  // ============================================================
  // timing in clock cycles
  localparam int          STROBE_CYCLES = 8;
  localparam logic [3:0]  STROBE_LAST   = 4'h7;

  // ============================================================
  // host request kinds
  typedef enum logic [1:0] {
    REQ_ADDR  = 2'b00,
    REQ_WRITE = 2'b01,
    REQ_READ  = 2'b10
  } req_kind_e;
endpackage : shared_bus_pkg
`default_nettype wire

//--- shared_bus_if.sv
// shared bus wires between host end and device end
`default_nettype none
interface shared_bus_if;
  import shared_bus_pkg::*;
  // ============================================================
  // host-driven pins
  logic  cmd;
  logic  wr_n;
  logic  rd_n;
  word_t host_sd_out;
  logic  host_sd_oe;
  // ============================================================
  // device-driven pins
  word_t dev_sd_out;
  logic  dev_sd_oe;
  // ============================================================
  // resolved level of the shared lines; pull-downs give zero when idle
  word_t sd;
  assign sd = dev_sd_oe  ? dev_sd_out  :
              host_sd_oe ? host_sd_out : WORD_ZERO;

  modport host (
    output cmd,
    output wr_n,
    output rd_n,
    output host_sd_out,
    output host_sd_oe,
    input  sd
  );
  modport device (
    input  cmd,
    input  wr_n,
    input  rd_n,
    input  sd,
    output dev_sd_out,
    output dev_sd_oe
  );
endinterface : shared_bus_if
`default_nettype wire

//--- shared_bus_host.sv
// host end: turns user requests into address and data cycles on the bus
`default_nettype none
module shared_bus_host (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // bus width, high for 16-bit mode
  input  wire logic                      mode16,
  // shared bus
  shared_bus_if.host                     bus,
  // user request
  input  wire logic                      req_valid,
  input  wire shared_bus_pkg::req_kind_e req_kind,
  input  wire shared_bus_pkg::addr_t     req_addr,
  input  wire shared_bus_pkg::lanes_t    req_lanes,
  input  wire shared_bus_pkg::word_t     req_word,
  // user answer
  output var  logic                      busy,
  output var  logic                      rd_valid,
  output var  shared_bus_pkg::word_t     rd_word
);
  import shared_bus_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } state_e;

  // ============================================================
  // input synchroniser for the read data
  word_t sd_meta;
  word_t sd_sync;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sd_meta <= WORD_ZERO;
      sd_sync <= WORD_ZERO;
    end else begin
      sd_meta <= bus.sd;
      sd_sync <= sd_meta;
    end
  end

  // ============================================================
  // words put on the pins
  state_e     state;
  logic [3:0] count;
  logic       is_read;
  logic       is_addr;
  logic       second;
  addr_t      held_addr;
  word_t      wide_addr_word;
  word_t      first_word;
  word_t      second_word;
  word_t      data_word;
  word_t      start_word;

  assign wide_addr_word = {req_lanes, 1'b0, req_addr[A16_MSB:A16_LSB],
                           2'b00};
  // upper byte driven low in byte mode
  assign first_word  = {BYTE_ZERO, req_addr[LOW_MSB:0]};
  assign second_word = {13'h0000, held_addr[A16_MSB:HIGH_LSB]};
  assign data_word   = mode16 ? req_word
                              : {BYTE_ZERO, req_word[LOW_MSB:0]};
  assign start_word  = (req_kind == REQ_ADDR)
                       ? (mode16 ? wide_addr_word : first_word) : data_word;

  // ============================================================
  // cycle sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      count           <= 4'h0;
      is_read         <= 1'b0;
      is_addr         <= 1'b0;
      second          <= 1'b0;
      held_addr       <= ADDR_ZERO;
      busy            <= 1'b0;
      rd_valid        <= 1'b0;
      rd_word         <= WORD_ZERO;
      bus.cmd         <= 1'b0;
      bus.wr_n        <= 1'b1;
      bus.rd_n        <= 1'b1;
      bus.host_sd_out <= WORD_ZERO;
      bus.host_sd_oe  <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req_valid) begin
            state           <= ST_SETUP;
            busy            <= 1'b1;
            is_read         <= (req_kind == REQ_READ);
            is_addr         <= (req_kind == REQ_ADDR);
            second          <= 1'b0;
            held_addr       <= req_addr;
            bus.cmd         <= (req_kind == REQ_ADDR);
            bus.host_sd_out <= start_word;
            bus.host_sd_oe  <= (req_kind != REQ_READ);
          end
        end
        ST_SETUP: begin
          state <= ST_STROBE;
          count <= STROBE_LAST;
          if (is_read) begin
            bus.rd_n <= 1'b0;
          end else begin
            bus.wr_n <= 1'b0;
          end
        end
        ST_STROBE: begin
          count <= count - 4'h1;
          if (count == 4'h0) begin
            state    <= ST_HOLD;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
            if (is_read) begin
              rd_valid <= 1'b1;
              rd_word  <= mode16 ? sd_sync
                                 : {BYTE_ZERO, sd_sync[LOW_MSB:0]};
            end
          end
        end
        ST_HOLD: begin
          // byte mode address takes a second write for the top bits
          if (is_addr && !mode16 && !second) begin
            state           <= ST_SETUP;
            second          <= 1'b1;
            bus.host_sd_out <= second_word;
          end else begin
            state           <= ST_IDLE;
            busy            <= 1'b0;
            bus.cmd         <= 1'b0;
            bus.host_sd_oe  <= 1'b0;
            bus.host_sd_out <= WORD_ZERO;
          end
        end
      endcase
    end
  end
endmodule : shared_bus_host
`default_nettype wire

//--- shared_bus_monitor.sv
// concurrent checks on the shared bus between host end and device end
`default_nettype none
module shared_bus_monitor (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rst_n,
  // bus width
  input wire logic                  mode16,
  // shared bus
  input wire logic                  cmd,
  input wire logic                  wr_n,
  input wire logic                  rd_n,
  input wire shared_bus_pkg::word_t host_sd_out,
  input wire logic                  host_sd_oe,
  input wire shared_bus_pkg::word_t dev_sd_out,
  input wire logic                  dev_sd_oe,
  input wire shared_bus_pkg::word_t sd
);
  import shared_bus_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ============================================================
  // steps of a transfer
  sequence write_start;
    $fell(wr_n);
  endsequence
  sequence strobe_held;
    !wr_n [*8];
  endsequence
  sequence read_start;
    $fell(rd_n) && !cmd;
  endsequence
  // ============================================================
  // checks
  strobe_len_a: assert property (
    write_start |-> strobe_held ##1 wr_n)
    else $error("write strobe not eight cycles low");
  // the first low cycle is skipped: lines were set only one edge earlier
  phase_stable_a: assert property (
    write_start |=> ($stable(cmd) && $stable(host_sd_out)) [*7])
    else $error("select or lines moved under write strobe");
  no_fight_a: assert property (!(host_sd_oe && dev_sd_oe))
    else $error("both ends drive the lines");
  write_drive_a: assert property (
    !wr_n |-> host_sd_oe && sd == host_sd_out)
    else $error("lines not driven by host during write");
  byte_high_a: assert property (
    host_sd_oe && !mode16 |-> host_sd_out[15:8] == BYTE_ZERO)
    else $error("upper byte not grounded in byte mode");
  byte_read_a: assert property (
    dev_sd_oe && !mode16 |-> dev_sd_out[15:8] == BYTE_ZERO)
    else $error("device drives upper byte in byte mode");
  wide_unused_a: assert property (
    cmd && mode16 && host_sd_oe |-> !host_sd_out[11] && !host_sd_out[1:0])
    else $error("unused address pins not zero");
  read_answer_a: assert property (read_start |-> ##[1:4] dev_sd_oe)
    else $error("device did not drive read data");
  read_quiet_a: assert property (!rd_n |-> !host_sd_oe)
    else $error("host drives lines during read");
endmodule : shared_bus_monitor
`default_nettype wire

//--- shared_bus_addr_data_demux_tb_top.sv
// testbench: host end facing device end across the shared bus
`default_nettype none
module shared_bus_addr_data_demux_tb_top;
  import shared_bus_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // stimulus and observed signals
  logic      clock       = 1'b0;
  logic      rst_n       = 1'b0;
  logic      mode16      = 1'b1;
  logic      req_valid   = 1'b0;
  req_kind_e req_kind    = REQ_ADDR;
  addr_t     req_addr    = ADDR_ZERO;
  lanes_t    req_lanes   = LANES_ZERO;
  word_t     req_word    = WORD_ZERO;
  word_t     dev_rd_word = WORD_ZERO;
  logic      busy;
  logic      rd_valid;
  logic      wr_pulse;
  logic      rd_pulse;
  word_t     host_rd_word;
  word_t     wr_word;
  addr_t     access_addr;
  lanes_t    access_lanes;
  int        mismatches   = 0;
  int        total_checks = 0;
  int        wr_seen      = 0;
  int        rd_seen      = 0;
  int        rdp_seen     = 0;

  always #5 clock = ~clock;

  shared_bus_if bus ();
  shared_bus_host u_shared_bus_host (
    .clock(clock), .rst_n(rst_n), .mode16(mode16), .bus(bus),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_word(req_word), .busy(busy),
    .rd_valid(rd_valid), .rd_word(host_rd_word)
  );
  shared_bus_device u_shared_bus_device (
    .clock(clock), .rst_n(rst_n), .mode16(mode16), .bus(bus),
    .access_addr(access_addr), .access_lanes(access_lanes),
    .wr_pulse(wr_pulse), .wr_word(wr_word), .rd_pulse(rd_pulse),
    .rd_word(dev_rd_word)
  );
  shared_bus_monitor u_shared_bus_monitor (
    .clock(clock), .rst_n(rst_n), .mode16(mode16), .cmd(bus.cmd),
    .wr_n(bus.wr_n), .rd_n(bus.rd_n), .host_sd_out(bus.host_sd_out),
    .host_sd_oe(bus.host_sd_oe), .dev_sd_out(bus.dev_sd_out),
    .dev_sd_oe(bus.dev_sd_oe), .sd(bus.sd)
  );

  // pulses are counted so a stuck or doubled pulse shows at the end
  always @(posedge clock) begin
    if (wr_pulse === 1'b1) wr_seen <= wr_seen + 1;
    if (rd_valid === 1'b1) rd_seen <= rd_seen + 1;
    if (rd_pulse === 1'b1) rdp_seen <= rdp_seen + 1;
  end

  // ============================================================
  // shared tasks
  task automatic chk(input word_t seen, input word_t exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // device lags the host by its input synchronisers, hence the tail wait
  task automatic req(input req_kind_e k, input addr_t a,
                     input lanes_t l, input word_t w);
    int n;
    @(negedge clock);
    req_kind  = k;
    req_addr  = a;
    req_lanes = l;
    req_word  = w;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
    end
    repeat (6) @(negedge clock);
  endtask : req

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ============================================================
  // scenarios
  task automatic t_wide();
    req(REQ_ADDR, 11'h003, 4'h4, WORD_ZERO);
    chk(word_t'(access_addr), 16'h0000);
    chk(word_t'(access_lanes), 16'h0004);
    req(REQ_ADDR, 11'h7FF, 4'hB, WORD_ZERO);
    chk(word_t'(access_addr), 16'h07FC);
    chk(word_t'(access_lanes), 16'h000B);
    req(REQ_WRITE, ADDR_ZERO, LANES_ZERO, 16'hA5C3);
    chk(wr_word, 16'hA5C3);
    req(REQ_WRITE, ADDR_ZERO, LANES_ZERO, 16'h0F01);
    chk(wr_word, 16'h0F01);
    chk(word_t'(access_addr), 16'h07FC);
    dev_rd_word = 16'h5AF0;
    req(REQ_READ, ADDR_ZERO, LANES_ZERO, WORD_ZERO);
    chk(host_rd_word, 16'h5AF0);
    chk(word_t'(access_lanes), 16'h000B);
  endtask : t_wide

  task automatic t_byte();
    @(negedge clock);
    mode16 = 1'b0;
    req(REQ_ADDR, 11'h5A7, LANES_ZERO, WORD_ZERO);
    chk(word_t'(access_addr), 16'h05A7);
    chk(word_t'(access_lanes), 16'h0008);
    req(REQ_WRITE, ADDR_ZERO, LANES_ZERO, 16'hBEEF);
    chk(wr_word, 16'h00EF);
    dev_rd_word = 16'h1234;
    req(REQ_READ, ADDR_ZERO, LANES_ZERO, WORD_ZERO);
    chk(host_rd_word, 16'h0034);
    req(REQ_ADDR, 11'h2D8, LANES_ZERO, WORD_ZERO);
    chk(word_t'(access_addr), 16'h02D8);
    chk(word_t'(access_lanes), 16'h0001);
  endtask : t_byte

  // ============================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    t_wide();
    t_byte();
    chk(word_t'(wr_seen), 16'h0003);
    chk(word_t'(rd_seen), 16'h0002);
    chk(word_t'(rdp_seen), 16'h0002);
    close_out();
  end

  initial begin
    #20000;
    mismatches++;
    close_out();
  end
endmodule : shared_bus_addr_data_demux_tb_top
`default_nettype wire
